// ---- rtl/sdp_pkg.sv ----
package sdp_pkg;
  localparam int DQ_W  = 32;
  localparam int DM_W  = 4;
  localparam int BA_W  = 2;
  localparam int ROW_W = 11;
  localparam int COL_W = 8;
  localparam int AP_BIT = 10;
  localparam int DQM_LAT = 2;

  // Command code {cs_n, ras_n, cas_n, we_n}
  localparam logic [3:0] CMD_LMR = 4'h0;
  localparam logic [3:0] CMD_REF = 4'h1;
  localparam logic [3:0] CMD_PRE = 4'h2;
  localparam logic [3:0] CMD_ACT = 4'h3;
  localparam logic [3:0] CMD_WR  = 4'h4;
  localparam logic [3:0] CMD_RD  = 4'h5;
  localparam logic [3:0] CMD_BST = 4'h6;
  localparam logic [3:0] CMD_NOP = 4'h7;
  localparam logic [3:0] CMD_INH = 4'hf;

  // Mode word fields
  localparam int MODE_BL_LSB = 0;
  localparam int MODE_CL_LSB = 4;
  localparam logic [2:0] BL_FULL = 3'h7;
  localparam logic [ROW_W-1:0] MODE_RST = 11'h020;

  // Controller register map
  localparam logic [7:0] REG_CMD    = 8'h00;
  localparam logic [7:0] REG_CTRL   = 8'h04;
  localparam logic [7:0] REG_WDATA  = 8'h08;
  localparam logic [7:0] REG_DQM    = 8'h0c;
  localparam logic [7:0] REG_RDATA  = 8'h10;
  localparam logic [7:0] REG_STATUS = 8'h14;
  localparam int CMD_BA_LSB   = 4;
  localparam int CMD_ADDR_LSB = 16;
  localparam int CTRL_CKE     = 0;
  localparam int CTRL_DRIVE   = 1;
  localparam int CTRL_CAPTURE = 2;
  localparam int STAT_ERR     = 0;
  localparam int STAT_OPEN_LSB = 4;
  localparam logic [2:0] CTRL_RST = 3'h0;
  localparam logic [DM_W-1:0] DQM_RST = 4'hf;

  typedef enum logic [2:0] {
    SDP_RUN  = 3'b000,
    SDP_SUSP = 3'b001,
    SDP_APD  = 3'b010,
    SDP_PPD  = 3'b011,
    SDP_SREF = 3'b100
  } sdp_pwr_t;
endpackage

// ---- rtl/sdp_if.sv ----
`timescale 1ns/1ps
interface sdp_if;
  logic                        cke;
  logic                        cs_n;
  logic                        ras_n;
  logic                        cas_n;
  logic                        we_n;
  logic [sdp_pkg::BA_W-1:0]    ba;
  logic [sdp_pkg::ROW_W-1:0]   addr;
  logic [sdp_pkg::DM_W-1:0]    dqm;
  logic [sdp_pkg::DQ_W-1:0]    ctl_dq_o;
  logic                        ctl_dq_oe;
  logic [sdp_pkg::DQ_W-1:0]    mem_dq_o;
  logic [sdp_pkg::DM_W-1:0]    mem_dq_oe;
  logic [sdp_pkg::DQ_W-1:0]    dq;

  // Resolved data wire; an undriven lane reads as zero
  always_comb begin
    for (int i = 0; i < sdp_pkg::DM_W; i++) begin
      if (ctl_dq_oe)
        dq[i*8 +: 8] = ctl_dq_o[i*8 +: 8];
      else if (mem_dq_oe[i])
        dq[i*8 +: 8] = mem_dq_o[i*8 +: 8];
      else
        dq[i*8 +: 8] = 8'h00;
    end
  end

  modport mem (input cke, cs_n, ras_n, cas_n, we_n, ba, addr, dqm, dq,
               output mem_dq_o, mem_dq_oe);
  modport ctl (output cke, cs_n, ras_n, cas_n, we_n, ba, addr, dqm,
               ctl_dq_o, ctl_dq_oe,
               input dq);
endinterface

// ---- rtl/sdp_mem_end.sv ----
// Behaviour
// - Inputs captured only at rising clock edge
// - Enabled edge advances burst, clocks outputs
// - Clock enable low suspends internal clocking
// - Enable low picks power-down, refresh or suspend
// - Clock enable asynchronous-like during power-down
// - Input buffers off in power-down, self refresh
// - Controller may hold clock enable high
// - Commands decoded only with chip select low
// - Bursts and masks continue while deselected
// - Command from select plus three strobes
// - Masked write lanes keep array byte
// - Read mask floats lane two edges later
// - Mask bit n governs data byte n
// - Bank inputs select one of four banks
// - Row from eleven lines, column eight
// - Line 10 selects auto precharge on access
// - Precharge: line 10 high means all banks
// - Load mode takes opcode from address
// - Select and strobes are active low
// - Bank is 2048 rows by 256 words
// - Row opened by activate before access
`timescale 1ns/1ps
module sdp_mem_end #(
  parameter int ROW_W = sdp_pkg::ROW_W,
  parameter int COL_W = sdp_pkg::COL_W
) (
  input  wire logic                     pclk,
  input  wire logic                     presetn,
  sdp_if.mem                            bus,
  output sdp_pkg::sdp_pwr_t             pwr_state,
  output logic [(1<<sdp_pkg::BA_W)-1:0] rows_open
);
  localparam int BANKS = 1 << sdp_pkg::BA_W;
  localparam int WORDS = BANKS << (ROW_W + COL_W);

  // Row width is tied to the address pins of the shared carrier
  if (ROW_W != sdp_pkg::ROW_W || COL_W >= ROW_W || COL_W > 8) begin : g_chk
    $error("sdp_mem_end: unsupported row or column width");
  end

  function automatic int unsigned word_idx(
    input logic [sdp_pkg::BA_W-1:0] b,
    input logic [ROW_W-1:0]         r,
    input logic [COL_W-1:0]         c);
    word_idx = int'({b, r, c});
  endfunction

  // Burst length in words; zero stands for endless full page
  function automatic logic [8:0] burst_len(input logic [2:0] code);
    unique case (code)
      3'h0:    burst_len = 9'h001;
      3'h1:    burst_len = 9'h002;
      3'h2:    burst_len = 9'h004;
      3'h3:    burst_len = 9'h008;
      default: burst_len = 9'h000;
    endcase
  endfunction

  // Sequential order wrapping inside the burst block
  function automatic logic [COL_W-1:0] next_col(
    input logic [COL_W-1:0] c, input logic [8:0] bl);
    logic [COL_W-1:0] m;
    m = (bl == 9'h000) ? '1 : COL_W'(bl - 9'h001);
    next_col = (c & ~m) | ((c + COL_W'(1)) & m);
  endfunction

  logic [sdp_pkg::DQ_W-1:0] mem [WORDS];

  sdp_pkg::sdp_pwr_t          pwr_q;
  logic [ROW_W-1:0]           mode_q;
  logic [BANKS-1:0]           open_q;
  logic [ROW_W-1:0]           row_q [BANKS];
  logic                       rd_act_q;
  logic                       wr_act_q;
  logic                       ap_q;
  logic [sdp_pkg::BA_W-1:0]   bank_q;
  logic [COL_W-1:0]           col_q;
  logic [8:0]                 rem_q;
  logic [sdp_pkg::DQ_W-1:0]   pd_q [2];
  logic [1:0]                 pv_q;
  logic [sdp_pkg::DM_W-1:0]   dqm_q;
  logic [sdp_pkg::DQ_W-1:0]   dq_out_q;
  logic [sdp_pkg::DM_W-1:0]   dq_oe_q;

  logic [3:0]               cmd;
  logic                     buf_on;
  logic                     tick;
  logic                     cmd_ok;
  logic                     start;
  logic                     stop;
  logic                     xfer_rd;
  logic                     xfer_wr;
  logic                     last;
  logic                     burst_end;
  logic [8:0]               bl;
  logic [2:0]               cl;
  logic [sdp_pkg::BA_W-1:0] x_bank;
  logic [COL_W-1:0]         x_col;
  logic                     x_ap;
  logic [sdp_pkg::DQ_W-1:0] fetch;

  assign cmd    = {bus.cs_n, bus.ras_n, bus.cas_n, bus.we_n};
  assign buf_on = (pwr_q == sdp_pkg::SDP_RUN)
               || (pwr_q == sdp_pkg::SDP_SUSP);
  assign tick   = buf_on && bus.cke;
  assign cmd_ok = tick && !bus.cs_n;
  assign bl     = burst_len(mode_q[sdp_pkg::MODE_BL_LSB +: 3]);
  assign cl     = mode_q[sdp_pkg::MODE_CL_LSB +: 3];

  assign start = cmd_ok && (cmd == sdp_pkg::CMD_RD || cmd == sdp_pkg::CMD_WR);
  assign stop  = cmd_ok && (cmd == sdp_pkg::CMD_BST
              || (cmd == sdp_pkg::CMD_PRE
                  && (bus.addr[sdp_pkg::AP_BIT] || bus.ba == bank_q)));
  // Burst keeps going regardless of chip select
  assign xfer_rd = tick && (start ? cmd == sdp_pkg::CMD_RD
                                  : rd_act_q && !stop);
  assign xfer_wr = tick && (start ? cmd == sdp_pkg::CMD_WR
                                  : wr_act_q && !stop);
  assign x_bank  = start ? bus.ba : bank_q;
  assign x_col   = start ? bus.addr[COL_W-1:0] : col_q;
  assign x_ap    = start ? bus.addr[sdp_pkg::AP_BIT] : ap_q;
  assign last    = start ? (bl == 9'h001) : (rem_q == 9'h001);
  assign burst_end = (xfer_rd || xfer_wr) && last;
  assign fetch   = mem[word_idx(x_bank, row_q[x_bank], x_col)];

  // Clock enable is looked at even with buffers off so exit is seen
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pwr_q <= sdp_pkg::SDP_PPD;
    end else if (bus.cke) begin
      pwr_q <= sdp_pkg::SDP_RUN;
    end else if (pwr_q == sdp_pkg::SDP_RUN) begin
      // A word still on the lanes counts as a burst in progress
      if (rd_act_q || wr_act_q || pv_q != 2'b00 || dq_oe_q != '0)
        pwr_q <= sdp_pkg::SDP_SUSP;
      else if (open_q != '0)
        pwr_q <= sdp_pkg::SDP_APD;
      else if (!bus.cs_n && cmd == sdp_pkg::CMD_REF)
        pwr_q <= sdp_pkg::SDP_SREF;
      else
        pwr_q <= sdp_pkg::SDP_PPD;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      mode_q <= sdp_pkg::MODE_RST;
    else if (cmd_ok && cmd == sdp_pkg::CMD_LMR)
      mode_q <= bus.addr;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      open_q <= '0;
      for (int b = 0; b < BANKS; b++)
        row_q[b] <= '0;
    end else begin
      if (burst_end && x_ap)
        open_q[x_bank] <= 1'b0;
      if (cmd_ok && cmd == sdp_pkg::CMD_ACT) begin
        open_q[bus.ba] <= 1'b1;
        row_q[bus.ba]  <= bus.addr;
      end else if (cmd_ok && cmd == sdp_pkg::CMD_PRE) begin
        if (bus.addr[sdp_pkg::AP_BIT])
          open_q <= '0;
        else
          open_q[bus.ba] <= 1'b0;
      end
    end
  end

  // Burst column counter steps only on enabled edges
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rd_act_q <= 1'b0;
      wr_act_q <= 1'b0;
      ap_q     <= 1'b0;
      bank_q   <= '0;
      col_q    <= '0;
      rem_q    <= '0;
    end else if (tick) begin
      if (start) begin
        rd_act_q <= (cmd == sdp_pkg::CMD_RD) && !last;
        wr_act_q <= (cmd == sdp_pkg::CMD_WR) && !last;
        ap_q     <= x_ap;
        bank_q   <= x_bank;
        rem_q    <= (bl == 9'h000) ? 9'h000 : bl - 9'h001;
        col_q    <= next_col(x_col, bl);
      end else if (xfer_rd || xfer_wr) begin
        rd_act_q <= rd_act_q && !last;
        wr_act_q <= wr_act_q && !last;
        if (rem_q != 9'h000)
          rem_q <= rem_q - 9'h001;
        col_q <= next_col(col_q, bl);
      end else if (stop) begin
        rd_act_q <= 1'b0;
        wr_act_q <= 1'b0;
      end
    end
  end

  // Array has no reset; contents are undefined until written
  always_ff @(posedge pclk) begin
    if (xfer_wr) begin
      for (int i = 0; i < sdp_pkg::DM_W; i++) begin
        if (!bus.dqm[i])
          mem[word_idx(x_bank, row_q[x_bank], x_col)][i*8 +: 8]
            <= bus.dq[i*8 +: 8];
      end
    end
  end

  // Latency pipe, then the output register that drives the lanes
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pv_q     <= 2'b00;
      pd_q[0]  <= '0;
      pd_q[1]  <= '0;
      dqm_q    <= '1;
      dq_out_q <= '0;
      dq_oe_q  <= '0;
    end else if (!buf_on) begin
      pv_q    <= 2'b00;
      dq_oe_q <= '0;
    end else if (tick) begin
      pv_q    <= {pv_q[0], xfer_rd};
      pd_q[0] <= fetch;
      pd_q[1] <= pd_q[0];
      dqm_q   <= bus.dqm;
      unique case (cl)
        3'h1: begin
          dq_out_q <= fetch;
          dq_oe_q  <= {sdp_pkg::DM_W{xfer_rd}} & ~dqm_q;
        end
        3'h2: begin
          dq_out_q <= pd_q[0];
          dq_oe_q  <= {sdp_pkg::DM_W{pv_q[0]}} & ~dqm_q;
        end
        default: begin
          dq_out_q <= pd_q[1];
          dq_oe_q  <= {sdp_pkg::DM_W{pv_q[1]}} & ~dqm_q;
        end
      endcase
    end
  end

  assign bus.mem_dq_o  = dq_out_q;
  assign bus.mem_dq_oe = dq_oe_q;
  assign pwr_state     = pwr_q;
  assign rows_open     = open_q;
endmodule

// ---- rtl/sdp_ctl_end.sv ----
`timescale 1ns/1ps
module sdp_ctl_end (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic             pready,
  output logic [31:0]      prdata,
  output logic             pslverr,
  sdp_if.ctl               bus
);
  localparam int BANKS = 1 << sdp_pkg::BA_W;

  logic [3:0]                cmd_q;
  logic [sdp_pkg::BA_W-1:0]  ba_q;
  logic [sdp_pkg::ROW_W-1:0] addr_q;
  logic [2:0]                ctrl_q;
  logic [31:0]               wdata_q;
  logic [sdp_pkg::DM_W-1:0]  dqm_q;
  logic [31:0]               rdata_q;
  logic                      err_q;
  logic [BANKS-1:0]          open_q;
  logic                      pready_q;
  logic [31:0]               prdata_q;
  logic                      pslverr_q;

  logic                      setup;
  logic                      wr_take;
  logic                      cmd_wr;
  logic [3:0]                new_cmd;
  logic [sdp_pkg::BA_W-1:0]  new_ba;
  logic                      bad_order;
  logic                      mapped;

  assign setup   = psel && !penable && !pready_q;
  assign wr_take = psel && penable && pready_q && pwrite;
  assign cmd_wr  = wr_take && paddr == sdp_pkg::REG_CMD;
  assign new_cmd = pwdata[3:0];
  assign new_ba  = pwdata[sdp_pkg::CMD_BA_LSB +: sdp_pkg::BA_W];
  assign bad_order = (new_cmd == sdp_pkg::CMD_RD
                   || new_cmd == sdp_pkg::CMD_WR) && !open_q[new_ba];
  assign mapped  = paddr inside {sdp_pkg::REG_CMD, sdp_pkg::REG_CTRL,
                   sdp_pkg::REG_WDATA, sdp_pkg::REG_DQM,
                   sdp_pkg::REG_RDATA, sdp_pkg::REG_STATUS};

  // Answer registered in the setup cycle needs no wait state and keeps outputs clean
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_q  <= 1'b0;
      prdata_q  <= '0;
      pslverr_q <= 1'b0;
    end else if (setup) begin
      pready_q  <= 1'b1;
      pslverr_q <= !mapped;
      unique case (paddr)
        sdp_pkg::REG_CTRL:   prdata_q <= {29'h0, ctrl_q};
        sdp_pkg::REG_WDATA:  prdata_q <= wdata_q;
        sdp_pkg::REG_DQM:    prdata_q <= {28'h0, dqm_q};
        sdp_pkg::REG_RDATA:  prdata_q <= rdata_q;
        sdp_pkg::REG_STATUS: prdata_q <= {24'h0, open_q, 3'h0, err_q};
        default:             prdata_q <= '0;
      endcase
    end else begin
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
    end
  end

  // One command per register write, then back to deselect
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cmd_q  <= sdp_pkg::CMD_INH;
      ba_q   <= '0;
      addr_q <= '0;
    end else if (cmd_wr && !bad_order) begin
      cmd_q  <= new_cmd;
      ba_q   <= new_ba;
      addr_q <= pwdata[sdp_pkg::CMD_ADDR_LSB +: sdp_pkg::ROW_W];
    end else begin
      cmd_q  <= sdp_pkg::CMD_INH;
    end
  end

  // Row tracking mirrors what the memory holds open
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      open_q <= '0;
    end else if (cmd_wr && !bad_order) begin
      if (new_cmd == sdp_pkg::CMD_ACT)
        open_q[new_ba] <= 1'b1;
      else if (new_cmd == sdp_pkg::CMD_PRE)
        open_q <= pwdata[sdp_pkg::CMD_ADDR_LSB + sdp_pkg::AP_BIT]
                ? '0 : open_q & ~(BANKS'(1) << new_ba);
      else if ((new_cmd == sdp_pkg::CMD_RD || new_cmd == sdp_pkg::CMD_WR)
               && pwdata[sdp_pkg::CMD_ADDR_LSB + sdp_pkg::AP_BIT])
        open_q[new_ba] <= 1'b0;
    end
  end

  // Refused access sets the flag; a new refusal beats the clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      err_q <= 1'b0;
    else if (cmd_wr && bad_order)
      err_q <= 1'b1;
    else if (wr_take && paddr == sdp_pkg::REG_STATUS && pwdata[0])
      err_q <= 1'b0;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q  <= sdp_pkg::CTRL_RST;
      wdata_q <= '0;
      dqm_q   <= sdp_pkg::DQM_RST;
    end else if (wr_take) begin
      if (paddr == sdp_pkg::REG_CTRL)
        ctrl_q <= pwdata[2:0];
      if (paddr == sdp_pkg::REG_WDATA)
        wdata_q <= pwdata;
      if (paddr == sdp_pkg::REG_DQM)
        dqm_q <= pwdata[sdp_pkg::DM_W-1:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      rdata_q <= '0;
    else if (ctrl_q[sdp_pkg::CTRL_CAPTURE])
      rdata_q <= bus.dq;
  end

  assign bus.cs_n      = cmd_q[3];
  assign bus.ras_n     = cmd_q[2];
  assign bus.cas_n     = cmd_q[1];
  assign bus.we_n      = cmd_q[0];
  assign bus.ba        = ba_q;
  assign bus.addr      = addr_q;
  assign bus.cke       = ctrl_q[sdp_pkg::CTRL_CKE];
  assign bus.dqm       = dqm_q;
  assign bus.ctl_dq_o  = wdata_q;
  assign bus.ctl_dq_oe = ctrl_q[sdp_pkg::CTRL_DRIVE];
  assign pready        = pready_q;
  assign prdata        = prdata_q;
  assign pslverr       = pslverr_q;
endmodule

// ---- bench/sdp_chk_props.sv ----
`timescale 1ns/1ps
module sdp_chk_props (
  input wire logic              pclk,
  input wire logic              presetn,
  input wire logic              cke,
  input wire logic              cs_n,
  input wire logic              ras_n,
  input wire logic              cas_n,
  input wire logic              we_n,
  input wire logic [1:0]        ba,
  input wire logic [10:0]       addr,
  input wire logic [3:0]        dqm,
  input wire logic [31:0]       mem_dq_o,
  input wire logic [3:0]        mem_dq_oe,
  input wire logic              ctl_dq_oe,
  input wire sdp_pkg::sdp_pwr_t pwr_state,
  input wire logic [3:0]        rows_open
);
  logic [3:0] cmd;
  logic       run;
  logic [1:0] cl_q;
  logic [2:0] since_q;
  assign cmd = {cs_n, ras_n, cas_n, we_n};
  assign run = cke && pwr_state == sdp_pkg::SDP_RUN;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Latency tracked here, since the mode word is not visible
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cl_q <= 2'h2;
    end else if (run && cmd == sdp_pkg::CMD_LMR) begin
      cl_q <= (addr[6:4] == 3'h1) ? 2'h1 :
              (addr[6:4] == 3'h2) ? 2'h2 : 2'h3;
    end
  end
  // Saturates so a stale read never matches a latency
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      since_q <= 3'h7;
    end else if (run && cmd == sdp_pkg::CMD_RD) begin
      since_q <= 3'h1;
    end else if (cke && since_q != 3'h7) begin
      since_q <= since_q + 3'h1;
    end
  end
  reset_idle_a: assert property ($rose(presetn) |-> cs_n && !cke &&
    dqm == 4'hf && !ctl_dq_oe) else $error("pins not idle after reset");
  cmd_once_a: assert property (!cs_n |=> cs_n)
    else $error("command held past one cycle");
  bus_owner_a: assert property (!(ctl_dq_oe && mem_dq_oe != 4'h0))
    else $error("both ends drive data");
  for (genvar i = 0; i < 4; i++) begin : g_lane
    dqm_float_a: assert property ((run && dqm[i]) ##1 cke
      |=> !mem_dq_oe[i]) else $error("masked lane still driven");
  end
  rd_latency_a: assert property ($rose(|mem_dq_oe) |-> since_q == cl_q)
    else $error("read data at wrong latency");
  susp_hold_a: assert property ((!cke && |mem_dq_oe)
    |=> $stable(mem_dq_o)) else $error("output moved while suspended");
  pd_quiet_a: assert property (pwr_state inside {sdp_pkg::SDP_APD,
    sdp_pkg::SDP_PPD, sdp_pkg::SDP_SREF} |-> mem_dq_oe == 4'h0)
    else $error("output driven in power-down");
  cke_low_a: assert property ((!cke && pwr_state == sdp_pkg::SDP_RUN
    && cs_n && mem_dq_oe == 4'h0 && since_q == 3'h7) |=> pwr_state ==
    (($past(rows_open) != 4'h0) ? sdp_pkg::SDP_APD : sdp_pkg::SDP_PPD))
    else $error("wrong low-power state");
  act_open_a: assert property ((run && cmd == sdp_pkg::CMD_ACT)
    |=> rows_open == ($past(rows_open) | (4'h1 << $past(ba))))
    else $error("activate did not open bank");
  pre_all_a: assert property ((run && cmd == sdp_pkg::CMD_PRE
    && addr[10]) |=> rows_open == 4'h0) else $error("banks left open");
  pre_one_a: assert property ((run && cmd == sdp_pkg::CMD_PRE
    && !addr[10]) |=> rows_open == ($past(rows_open) & ~(4'h1 << $past(ba))))
    else $error("wrong bank closed");
  cover property (run && cmd == sdp_pkg::CMD_RD);
  cover property ($rose(pwr_state == sdp_pkg::SDP_SUSP));
  cover property (rows_open == 4'hb);
endmodule

// ---- bench/tb_sdram_pin_command_interface.sv ----
`timescale 1ns/1ps
`define CHK(got, exp, msg) begin total_checks++; if ((got) !== (exp)) \
  begin mismatches++; $display("wrong value at %0t: %s", $time, msg); end end
module tb_sdram_pin_command_interface;
  logic              pclk = 1'b0;
  logic              presetn = 1'b0;
  logic              psel = 1'b0;
  logic              penable = 1'b0;
  logic              pwrite = 1'b0;
  logic [7:0]        paddr = 8'h00;
  logic [31:0]       pwdata = 32'h0;
  logic              pready;
  logic              pslverr;
  logic [31:0]       prdata;
  sdp_pkg::sdp_pwr_t pwr_state;
  logic [3:0]        rows_open;
  int                mismatches = 0;
  int                total_checks = 0;
  always #2.5 pclk = ~pclk;
  sdp_if sdp_if_inst ();
  sdp_mem_end sdp_mem_end_inst (.pclk(pclk), .presetn(presetn),
    .bus(sdp_if_inst), .pwr_state(pwr_state), .rows_open(rows_open));
  sdp_ctl_end sdp_ctl_end_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pready(pready), .prdata(prdata), .pslverr(pslverr), .bus(sdp_if_inst));
  sdp_chk_props sdp_chk_props_inst (.pclk(pclk), .presetn(presetn),
    .cke(sdp_if_inst.cke), .cs_n(sdp_if_inst.cs_n),
    .ras_n(sdp_if_inst.ras_n), .cas_n(sdp_if_inst.cas_n),
    .we_n(sdp_if_inst.we_n), .ba(sdp_if_inst.ba), .addr(sdp_if_inst.addr),
    .dqm(sdp_if_inst.dqm), .mem_dq_o(sdp_if_inst.mem_dq_o),
    .mem_dq_oe(sdp_if_inst.mem_dq_oe), .ctl_dq_oe(sdp_if_inst.ctl_dq_oe),
    .pwr_state(pwr_state), .rows_open(rows_open));

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // Holds the request until pready is seen high at a rising edge
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d, output logic [31:0] r,
                     output logic e);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 50) mismatches++;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic        e;
    apb(1'b1, a, d, r, e);
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] x,
                        input logic xe, input string m);
    logic [31:0] r;
    logic        e;
    apb(1'b0, a, 32'h0, r, e);
    `CHK(r, x, m)
    `CHK(e, xe, m)
  endtask

  task automatic cmd(input logic [3:0] c, input logic [1:0] b,
                     input logic [10:0] a);
    logic [31:0] d;
    d = 32'h0;
    d[3:0] = c;
    d[5:4] = b;
    d[26:16] = a;
    wr(sdp_pkg::REG_CMD, d);
  endtask

  task automatic rows_is(input logic [3:0] x, input string m);
    repeat (4) @(negedge pclk);
    `CHK(rows_open, x, m)
  endtask

  task automatic state_is(input sdp_pkg::sdp_pwr_t s, input string m);
    int n;
    n = 0;
    while (pwr_state !== s && n < 20) begin
      @(negedge pclk);
      n++;
    end
    `CHK(pwr_state, s, m)
  endtask

  // Address bits 8 and 9 above the low eight column bits are set and must be ignored
  task automatic rd_word(input logic [3:0] xoe, input logic [31:0] xq);
    int n;
    n = 0;
    cmd(sdp_pkg::CMD_RD, 2'h1, 11'h312);
    while (sdp_if_inst.mem_dq_oe === 4'h0 && n < 20) begin
      @(negedge pclk);
      n++;
    end
    `CHK(sdp_if_inst.mem_dq_oe, xoe, "read lanes")
    `CHK(sdp_if_inst.dq, xq, "read word")
  endtask

  task automatic t_reset();
    rd_chk(sdp_pkg::REG_CTRL, 32'h0, 1'b0, "ctrl reset");
    rd_chk(sdp_pkg::REG_DQM, 32'hf, 1'b0, "mask reset");
    rd_chk(8'h18, 32'h0, 1'b1, "unmapped read");
    `CHK(pwr_state, sdp_pkg::SDP_PPD, "reset state")
    wr(sdp_pkg::REG_CTRL, 32'h1);
    state_is(sdp_pkg::SDP_RUN, "wake");
  endtask

  task automatic t_write_read();
    cmd(sdp_pkg::CMD_LMR, 2'h0, sdp_pkg::MODE_RST);
    cmd(sdp_pkg::CMD_ACT, 2'h1, 11'h5a5);
    rows_is(4'h2, "bank one open");
    wr(sdp_pkg::REG_WDATA, 32'h11223344);
    wr(sdp_pkg::REG_DQM, 32'h0);
    wr(sdp_pkg::REG_CTRL, 32'h3);
    cmd(sdp_pkg::CMD_WR, 2'h1, 11'h012);
    wr(sdp_pkg::REG_WDATA, 32'haabbccdd);
    wr(sdp_pkg::REG_DQM, 32'h5);
    cmd(sdp_pkg::CMD_WR, 2'h1, 11'h012);
    wr(sdp_pkg::REG_CTRL, 32'h1);
    wr(sdp_pkg::REG_DQM, 32'h0);
    rd_word(4'hf, 32'haa22cc44);
    cmd(sdp_pkg::CMD_LMR, 2'h0, 11'h030);
    rd_word(4'hf, 32'haa22cc44);
    cmd(sdp_pkg::CMD_LMR, 2'h0, 11'h010);
    wr(sdp_pkg::REG_DQM, 32'h8);
    rd_word(4'h7, 32'h0022cc44);
    cmd(sdp_pkg::CMD_LMR, 2'h0, sdp_pkg::MODE_RST);
    wr(sdp_pkg::REG_DQM, 32'h0);
  endtask

  task automatic t_select();
    cmd(4'hb, 2'h2, 11'h000);
    rows_is(4'h2, "deselected activate");
    cmd(sdp_pkg::CMD_RD, 2'h3, 11'h000);
    rd_chk(sdp_pkg::REG_STATUS, 32'h21, 1'b0, "order error");
    wr(sdp_pkg::REG_STATUS, 32'h1);
    rd_chk(sdp_pkg::REG_STATUS, 32'h20, 1'b0, "error cleared");
    wr(sdp_pkg::REG_CTRL, 32'h7);
    wr(sdp_pkg::REG_CTRL, 32'h1);
    rd_chk(sdp_pkg::REG_RDATA, 32'haabbccdd, 1'b0, "captured bus");
  endtask

  task automatic t_precharge();
    cmd(sdp_pkg::CMD_ACT, 2'h0, 11'h000);
    cmd(sdp_pkg::CMD_ACT, 2'h3, 11'h7ff);
    rows_is(4'hb, "three open");
    cmd(sdp_pkg::CMD_PRE, 2'h3, 11'h000);
    rows_is(4'h3, "one closed");
    cmd(sdp_pkg::CMD_PRE, 2'h0, 11'h400);
    rows_is(4'h0, "all closed");
    cmd(sdp_pkg::CMD_ACT, 2'h2, 11'h123);
    rows_is(4'h4, "bank two open");
    wr(sdp_pkg::REG_CTRL, 32'h3);
    cmd(sdp_pkg::CMD_WR, 2'h2, 11'h4ff);
    wr(sdp_pkg::REG_CTRL, 32'h1);
    rows_is(4'h0, "auto precharge");
  endtask

  // Full-page read keeps a burst alive long enough to suspend it
  task automatic t_power();
    cmd(sdp_pkg::CMD_ACT, 2'h0, 11'h001);
    wr(sdp_pkg::REG_CTRL, 32'h0);
    state_is(sdp_pkg::SDP_APD, "active power-down");
    wr(sdp_pkg::REG_CTRL, 32'h1);
    state_is(sdp_pkg::SDP_RUN, "exit power-down");
    cmd(sdp_pkg::CMD_LMR, 2'h0, 11'h027);
    // Fill the first columns so the suspended word is defined
    wr(sdp_pkg::REG_CTRL, 32'h3);
    cmd(sdp_pkg::CMD_WR, 2'h0, 11'h000);
    cmd(sdp_pkg::CMD_BST, 2'h0, 11'h000);
    wr(sdp_pkg::REG_CTRL, 32'h1);
    cmd(sdp_pkg::CMD_RD, 2'h0, 11'h000);
    wr(sdp_pkg::REG_CTRL, 32'h0);
    state_is(sdp_pkg::SDP_SUSP, "suspend");
    `CHK(sdp_if_inst.dq, 32'haabbccdd, "suspended word")
    wr(sdp_pkg::REG_CTRL, 32'h1);
    state_is(sdp_pkg::SDP_RUN, "resume");
    cmd(sdp_pkg::CMD_BST, 2'h0, 11'h000);
    repeat (6) @(negedge pclk);
    `CHK(sdp_if_inst.mem_dq_oe, 4'h0, "burst stopped")
    cmd(sdp_pkg::CMD_LMR, 2'h0, sdp_pkg::MODE_RST);
    cmd(sdp_pkg::CMD_PRE, 2'h0, 11'h400);
    wr(sdp_pkg::REG_CTRL, 32'h0);
    state_is(sdp_pkg::SDP_PPD, "precharge power-down");
    wr(sdp_pkg::REG_CTRL, 32'h1);
    state_is(sdp_pkg::SDP_RUN, "exit idle");
  endtask

  initial begin
    repeat (20000) @(posedge pclk);
    mismatches++;
    tally_and_finish();
  end

  initial begin
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_write_read();
    t_select();
    t_precharge();
    t_power();
    tally_and_finish();
  end
endmodule
